//--- leio_pkg.sv
// leio_pkg: constants and types shared by the line event interrupt block.
// assumes a 32-bit axi4-lite register bus and a 50 MHz system clock.
package leio_pkg;

    // real-time status inputs watched for changes
    localparam int RT_W   = 8;
    // byte address width of the register window
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RT_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RT_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_STS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_INT_EN  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LINE    = 8'h14;

    // control register fields
    localparam int CTRL_OD_BIT   = 0;
    localparam int CTRL_ARM_BIT  = 1;
    localparam int CTRL_SRST_BIT = 2;

    // interrupt status / enable fields
    localparam int INT_W      = 2;
    localparam int INT_RT_BIT = 0;
    localparam int INT_TX_BIT = 1;

    // line state register fields
    localparam int LINE_ATT_BIT = 0;
    localparam int LINE_OD_BIT  = 1;
    localparam int LINE_ARM_BIT = 2;

    // values after reset
    localparam logic [RT_W-1:0]  RST_RT_MASK    = 8'hff;
    localparam logic             RST_OPEN_DRAIN = 1'b0;
    localparam logic             RST_TX_ARM     = 1'b0;
    localparam logic [INT_W-1:0] RST_INT_EN     = 2'h0;
    localparam logic [RT_W:0]    RST_SYNC       = 9'h100;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // whole state of the main module
    typedef struct packed {
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              open_drain;
        logic              tx_arm;
        logic [RT_W-1:0]   rt_mask;
        logic [RT_W-1:0]   rt_prev;
        logic              prev_ok;
        logic              att;
        logic [INT_W-1:0]  int_sts;
        logic [INT_W-1:0]  int_en;
    } leio_state_t;

endpackage : leio_pkg

//--- leio_sync.sv
// leio_sync: two-flop synchroniser for a bundle of asynchronous pins.
// assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps
module leio_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // pins and synchronised levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } leio_sync_state_t;

    leio_sync_state_t st_ff;
    leio_sync_state_t nxt_st;

    // the first stage feeds only the second stage
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = pin_i;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff <= {RST_VAL, RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.stable;

endmodule : leio_sync

//--- leio_top.sv
// leio_top: attention line generator with an axi4-lite register slave.
// assumes tx_data_new comes from logic on sys_clk; the status pins and the
// hardware reset pin are asynchronous and are synchronised here.
//
// Operation
// - attention line is asserted by driving it low; idle is high or off.
// - output stage is push-pull or open-drain, chosen by a control bit.
// - any unmasked real-time status bit change asserts the line.
// - when armed, each new transmit data event asserts the line.
// - asserted line holds until host reads the real-time data register.
// - while armed, the line is not held pending a register read.
// - soft reset or hardware reset releases the line unconditionally.
// - each status bit has its own mask, written and read by the host.
// - hardware reset low returns all state and configuration to default.
`timescale 1ns/1ps
module leio_top
    import leio_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // hardware reset pin, active low, asynchronous
    input  wire logic              hw_rst_n,
    // real-time status pins and transmit data event
    input  wire logic [RT_W-1:0]   rt_status,
    input  wire logic              tx_data_new,
    // attention line pin and system interrupt
    output logic                   attn_line_o,
    output logic                   attn_line_oe_n,
    output logic                   irq,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    leio_state_t     st_ff;
    leio_state_t     nxt_st;

    logic [RT_W:0]   sync_bus;
    logic [RT_W-1:0] rt_cur;
    logic            hw_rst_sync_n;
    logic            rst_all;

    // write decode results
    logic            wr_go;
    logic            wr_hit;
    logic            soft_rst;
    logic [INT_W-1:0] int_clr;
    logic [31:0]     merged;

    // read decode results
    logic            rd_go;
    logic            rd_rt;
    logic            rd_hit;
    logic [31:0]     rd_word;

    // event detection
    logic [RT_W-1:0] rt_change;
    logic            rt_event;
    logic            tx_event;
    logic [INT_W-1:0] int_set;

    // prot is accepted but not used: all registers are open to every access
    logic [2:0]      prot_unused;

    // applies the byte strobes of a write to an old register value
    function automatic logic [31:0] leio_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : leio_merge

    // true when a byte address selects one of the mapped registers
    function automatic logic leio_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CTRL)    || (a == OFS_RT_DATA) ||
               (a == OFS_RT_MASK) || (a == OFS_INT_STS) ||
               (a == OFS_INT_EN)  || (a == OFS_LINE);
    endfunction : leio_mapped

    // zero-extends a status-wide field into a bus word
    function automatic logic [31:0] leio_rt_word(input logic [RT_W-1:0] v);
        return {{(32-RT_W){1'b0}}, v};
    endfunction : leio_rt_word

    // zero-extends an interrupt-wide field into a bus word
    function automatic logic [31:0] leio_int_word(input logic [INT_W-1:0] v);
        return {{(32-INT_W){1'b0}}, v};
    endfunction : leio_int_word

    // control word as software sees it; the soft reset bit always reads 0
    function automatic logic [31:0] leio_ctrl_word(
        input logic od,
        input logic arm
    );
        logic [31:0] w;
        w               = '0;
        w[CTRL_OD_BIT]  = od;
        w[CTRL_ARM_BIT] = arm;
        return w;
    endfunction : leio_ctrl_word

    // line state word: attention, drive mode and arm in one read
    function automatic logic [31:0] leio_line_word(
        input logic att,
        input logic od,
        input logic arm
    );
        logic [31:0] w;
        w               = '0;
        w[LINE_ATT_BIT] = att;
        w[LINE_OD_BIT]  = od;
        w[LINE_ARM_BIT] = arm;
        return w;
    endfunction : leio_line_word

    // status pins and the reset pin share one synchroniser
    // a pin reset acts two edges late; a pulse under one clock may be missed
    leio_sync #(
        .W       (RT_W + 1),
        .RST_VAL (RST_SYNC)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pin_i   ({hw_rst_n, rt_status}),
        .sync_o  (sync_bus)
    );

    assign rt_cur        = sync_bus[RT_W-1:0];
    assign hw_rst_sync_n = sync_bus[RT_W];
    assign prot_unused   = s_axi_awprot | s_axi_arprot;

    // either reset source returns everything to default
    assign rst_all = sys_rst || !hw_rst_sync_n;

    // bus handshakes: one write and one read in flight at a time
    assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rresp   = st_ff.rresp;
    assign s_axi_rdata   = st_ff.rdata;

    // write takes effect once both address and data are held
    always_comb begin
        wr_go    = st_ff.aw_got && st_ff.w_got;
        wr_hit   = leio_mapped(st_ff.aw_addr);
        soft_rst = 1'b0;
        int_clr  = '0;
        merged   = '0;
        if (wr_go && st_ff.aw_addr == OFS_CTRL) begin
            // soft reset is a self-clearing command bit, never stored
            soft_rst = st_ff.w_strb[0] && st_ff.w_data[CTRL_SRST_BIT];
        end
        if (wr_go && st_ff.aw_addr == OFS_INT_STS && st_ff.w_strb[0]) begin
            int_clr = st_ff.w_data[INT_W-1:0];
        end
        if (wr_go) begin
            unique case (st_ff.aw_addr)
                OFS_CTRL: begin
                    merged = leio_merge(leio_ctrl_word(st_ff.open_drain,
                                                       st_ff.tx_arm),
                                        st_ff.w_data, st_ff.w_strb);
                end
                OFS_RT_MASK: begin
                    merged = leio_merge(leio_rt_word(st_ff.rt_mask),
                                        st_ff.w_data, st_ff.w_strb);
                end
                OFS_INT_EN: begin
                    merged = leio_merge(leio_int_word(st_ff.int_en),
                                        st_ff.w_data, st_ff.w_strb);
                end
                default: begin
                    merged = '0;
                end
            endcase
        end
    end

    // read decode; the word is captured at the address handshake
    always_comb begin
        rd_go   = s_axi_arvalid && s_axi_arready;
        rd_rt   = rd_go && (s_axi_araddr == OFS_RT_DATA);
        rd_hit  = leio_mapped(s_axi_araddr);
        rd_word = '0;
        unique case (s_axi_araddr)
            OFS_CTRL: begin
                rd_word = leio_ctrl_word(st_ff.open_drain, st_ff.tx_arm);
            end
            OFS_RT_DATA: begin
                rd_word = leio_rt_word(rt_cur);
            end
            OFS_RT_MASK: begin
                rd_word = leio_rt_word(st_ff.rt_mask);
            end
            OFS_INT_STS: begin
                rd_word = leio_int_word(st_ff.int_sts);
            end
            OFS_INT_EN: begin
                rd_word = leio_int_word(st_ff.int_en);
            end
            OFS_LINE: begin
                rd_word = leio_line_word(st_ff.att, st_ff.open_drain,
                                         st_ff.tx_arm);
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // events; the first sample after reset only seeds the history so that
    // a pin already high at a hardware reset release does not raise a false change
    always_comb begin
        rt_change = st_ff.prev_ok ? (rt_cur ^ st_ff.rt_prev) : '0;
        rt_event  = |(rt_change & ~st_ff.rt_mask);
        tx_event  = st_ff.tx_arm && tx_data_new;
        int_set   = '0;
        int_set[INT_RT_BIT] = rt_event;
        int_set[INT_TX_BIT] = tx_event;
    end

    always_comb begin
        nxt_st = st_ff;

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
            unique case (st_ff.aw_addr)
                OFS_CTRL: begin
                    nxt_st.open_drain = merged[CTRL_OD_BIT];
                    nxt_st.tx_arm     = merged[CTRL_ARM_BIT];
                end
                OFS_RT_MASK: begin
                    nxt_st.rt_mask = merged[RT_W-1:0];
                end
                OFS_INT_EN: begin
                    nxt_st.int_en = merged[INT_W-1:0];
                end
                default: begin
                    nxt_st.rt_mask = st_ff.rt_mask;
                end
            endcase
        end

        // read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_word;
            nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // history for change detection
        nxt_st.rt_prev = rt_cur;
        nxt_st.prev_ok = 1'b1;

        // attention line state
        if (soft_rst) begin
            nxt_st.att = 1'b0;
        end else if (st_ff.tx_arm) begin
            // armed: the line follows events, no latch on a read
            nxt_st.att = rt_event || tx_event;
        end else begin
            // a change in the same cycle as the read keeps the line low
            nxt_st.att = rt_event || (st_ff.att && !rd_rt);
        end

        // sticky interrupt status, write one to clear, a set wins
        if (soft_rst) begin
            nxt_st.int_sts = int_set;
        end else begin
            nxt_st.int_sts = (st_ff.int_sts & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            st_ff            <= '0;
            st_ff.open_drain <= RST_OPEN_DRAIN;
            st_ff.tx_arm     <= RST_TX_ARM;
            st_ff.rt_mask    <= RST_RT_MASK;
            st_ff.int_en     <= RST_INT_EN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // low means asserted; open drain only drives while asserted
    always_comb begin
        if (st_ff.open_drain) begin
            attn_line_o    = 1'b0;
            attn_line_oe_n = !st_ff.att;
        end else begin
            attn_line_o    = !st_ff.att;
            attn_line_oe_n = 1'b0;
        end
    end

    assign irq = |(st_ff.int_sts & st_ff.int_en);

endmodule : leio_top

//--- leio_properties.sv
// leio_properties: timing checks on the attention pin and read channel.
// assumes it is bound into leio_top and sees only its ports.
`timescale 1ns/1ps
module leio_properties
    import leio_pkg::*;
(
    // clock and resets
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              hw_rst_n,
    // pins
    input wire logic [RT_W-1:0]   rt_status,
    input wire logic              tx_data_new,
    input wire logic              attn_line_o,
    input wire logic              attn_line_oe_n,
    input wire logic              irq,
    // read channel and write response
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              s_axi_bvalid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [RT_W-1:0] rt_prev_ff;
    logic [2:0]      quiet_ff;
    logic            rel;

    // a pin change takes three edges to reach the line, so five
    // quiet samples mean no status event is still in flight
    always_ff @(posedge sys_clk) begin
        rt_prev_ff <= rt_status;
        if (sys_rst || !hw_rst_n || rt_status != rt_prev_ff) begin
            quiet_ff <= 3'h0;
        end else if (quiet_ff != 3'h7) begin
            quiet_ff <= quiet_ff + 3'h1;
        end
    end
    assign rel = attn_line_o | attn_line_oe_n;

    sequence hw_low_s;
        !hw_rst_n [*4];
    endsequence
    sequence rt_read_s;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_RT_DATA;
    endsequence

    chk_od_level: assert property (
        attn_line_oe_n |-> !attn_line_o)
        else $error("released pin carries a high level");
    chk_hw_release: assert property (
        hw_low_s |-> attn_line_o && !attn_line_oe_n && !irq)
        else $error("line not released in hardware reset");
    chk_hw_default: assert property (
        hw_low_s |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus answer pending in hardware reset");
    chk_read_release: assert property (
        rt_read_s ##0 (quiet_ff >= 3'h5 && !tx_data_new) ##1 !tx_data_new
        |=> rel)
        else $error("line still low after status read");
    chk_quiet_idle: assert property (
        rel && quiet_ff == 3'h7 && !tx_data_new |=> rel)
        else $error("line asserted with no event");
    chk_r_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_single: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_ar_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
endmodule : leio_properties

//--- leio_host.sv
// leio_host: host end of the attention wire, with the board pull-up.
// assumes nothing else drives the wire.
`timescale 1ns/1ps
module leio_host (
    // attention pin from the block
    input wire logic attn_line_o,
    input wire logic attn_line_oe_n,
    // level the host sees
    output logic     attn_wire
);
    // the pull-up lifts an undriven wire, so low always means service
    assign attn_wire = attn_line_oe_n ? 1'b1 : attn_line_o;
endmodule : leio_host

//--- leio_test.sv
// line_event_interrupt_output_test: self-checking bench for leio_top.
// assumes leio_top, leio_host and leio_properties are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module line_event_interrupt_output_test
    import leio_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              hw_rst_n = 1'b1;
    logic              tx_data_new = 1'b0;
    logic [RT_W-1:0]   rt_status = 8'h00;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
    logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_arready;
    logic              s_axi_bvalid, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
    logic [31:0]       s_axi_rdata, rd;
    logic              attn_line_o, attn_line_oe_n, irq, attn_wire;
    int                err_total = 0;
    int                n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    // the bench answers every response at once; protection is unused
    leio_top dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
        .s_axi_wstrb(4'hf), .s_axi_bready(1'b1), .s_axi_rready(1'b1), .*);
    leio_host u_host (.*);

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : rd_reg

    task automatic wait_wire(input logic lvl);
        int n;
        n = 0;
        while (attn_wire !== lvl && n < 12) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_wire

    task automatic t_defaults;
        rd_reg(OFS_RT_MASK);
        `CHK(rd[7:0], RST_RT_MASK)
        rd_reg(OFS_CTRL);
        `CHK(rd, 32'h0)
        `CHK(rs, RESP_OKAY)
        `CHK(attn_wire, 1'b1)
        `CHK(attn_line_oe_n, 1'b0)
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_hold_read;
        wr(OFS_RT_MASK, 32'hfe);
        `CHK(rs, RESP_OKAY)
        wr(OFS_INT_EN, 32'h1);
        rt_status <= 8'h02;
        repeat (10) @(posedge sys_clk);
        `CHK(attn_wire, 1'b1)
        rt_status <= 8'h03;
        wait_wire(1'b0);
        `CHK(attn_wire, 1'b0)
        repeat (20) @(posedge sys_clk);
        `CHK(attn_wire, 1'b0)
        `CHK(irq, 1'b1)
        wr(OFS_INT_EN, 32'h0);
        `CHK(irq, 1'b0)
        wr(OFS_INT_EN, 32'h1);
        rd_reg(OFS_LINE);
        `CHK(rd[LINE_ATT_BIT], 1'b1)
        // the host services the line by reading the status word
        rd_reg(OFS_RT_DATA);
        `CHK(rd[7:0], 8'h03)
        @(posedge sys_clk);
        `CHK(attn_wire, 1'b1)
        wr(OFS_INT_STS, 32'h1);
        `CHK(irq, 1'b0)
        $display("test hold and read done");
    endtask : t_hold_read

    task automatic t_soft_rst;
        rt_status <= 8'h02;
        wait_wire(1'b0);
        `CHK(attn_wire, 1'b0)
        wr(OFS_CTRL, 32'h4);
        `CHK(attn_wire, 1'b1)
        rd_reg(OFS_CTRL);
        `CHK(rd[CTRL_SRST_BIT], 1'b0)
        $display("test soft reset done");
    endtask : t_soft_rst

    task automatic t_armed;
        wr(OFS_CTRL, 32'h2);
        tx_data_new <= 1'b1;
        @(posedge sys_clk);
        tx_data_new <= 1'b0;
        @(posedge sys_clk);
        `CHK(attn_wire, 1'b0)
        @(posedge sys_clk);
        `CHK(attn_wire, 1'b1)
        rd_reg(OFS_INT_STS);
        `CHK(rd[INT_W-1:0], 2'h2)
        rt_status <= 8'h03;
        wait_wire(1'b0);
        @(posedge sys_clk);
        `CHK(attn_wire, 1'b1)
        wr(OFS_CTRL, 32'h0);
        tx_data_new <= 1'b1;
        @(posedge sys_clk);
        tx_data_new <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(attn_wire, 1'b1)
        $display("test armed done");
    endtask : t_armed

    task automatic t_open_drain;
        wr(OFS_CTRL, 32'h1);
        `CHK(attn_line_oe_n, 1'b1)
        rt_status <= 8'h02;
        wait_wire(1'b0);
        `CHK({attn_line_oe_n, attn_line_o}, 2'h0)
        rd_reg(OFS_RT_DATA);
        @(posedge sys_clk);
        `CHK(attn_line_oe_n, 1'b1)
        $display("test open drain done");
    endtask : t_open_drain

    task automatic t_hw_rst;
        rt_status <= 8'h03;
        wait_wire(1'b0);
        `CHK(attn_wire, 1'b0)
        hw_rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        `CHK({attn_wire, attn_line_oe_n}, 2'h2)
        hw_rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rd_reg(OFS_RT_MASK);
        `CHK(rd[7:0], RST_RT_MASK)
        rd_reg(8'h40);
        `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
        wr(8'h40, 32'h1);
        `CHK(rs, RESP_SLVERR)
        $display("test hardware reset done");
    endtask : t_hw_rst

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_defaults;
        t_hold_read;
        t_soft_rst;
        t_armed;
        t_open_drain;
        t_hw_rst;
        report_and_stop;
    end

    // the tests need well under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        report_and_stop;
    end
endmodule : line_event_interrupt_output_test

bind leio_top leio_properties u_props (.*);
